// file: design/tosc_top.sv
// trace output routing and trace session control, APB register slave
// assumes: packet source, retire signals and sinks share pclk; warm_rstn is
// synchronous to pclk and clears the control register and session state, never the output path
//
// Overview of operation
// - stream goes to buffer, ATB or extra output
// - buffer unit enabled: only buffer unit gets bytes
// - buffer unit disabled: ATB and extra outputs
// - ATB trigger and 7-bit source identifier reported
// - all outputs off: bytes count as sent
// - unit always enabled or disabled
// - session spans enable until next disable
// - view filter produces trace when operative
// - operative means enabled and not recovering
// - view filter independent of operative state
// - operative on enable or overflow recovery
// - inoperative on disable or buffer overflow
// - unemittable required packet declares overflow
// - output path survives processor warm reset
// - signpost byte only for control-flow instructions
// - alignment sync first whenever becoming operative
//
// Added by the designer: the APB interface to the registers and the address map.
`timescale 1ns/1ps
`default_nettype none
module tosc_top (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic warm_rstn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic pready,
    output logic [31:0] prdata,
    output logic pslverr,
    input wire logic pkt_valid,
    input wire logic [7:0] pkt_data,
    input wire logic retire_valid,
    input wire logic retire_signpost,
    output logic tbu_valid,
    output logic [7:0] tbu_data,
    input wire logic tbu_ready,
    output logic atb_valid,
    output logic [7:0] atb_data,
    output logic [6:0] atb_id,
    input wire logic atb_ready,
    input wire logic atb_trig_in,
    output logic imp_valid,
    output logic [7:0] imp_data,
    input wire logic imp_ready,
    output logic view_active,
    output logic gen_operative,
    output logic irq
);
    // all state in one struct, registered by one process
    typedef struct packed {
        logic [4:0] ctrl;
        logic [6:0] sid;
        logic [4:0] ev_stat;
        logic [4:0] ev_en;
        tosc_pkg::tosc_sess_t sess;
        logic [2:0] out_vld;
        logic [7:0] out_data;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
        logic irq;
        logic view;
        logic oper;
    } tosc_top_st_t;

    tosc_top_st_t st_reg;
    tosc_top_st_t st_next;

    logic access, wr, oper, unit_en, slot_free, recover_ok;
    logic sy_v, sp_v, pk_v, want, multi, lost, take, start, al_busy;
    logic [2:0] dest, done_vld, vld_after;
    logic [7:0] byte_sel, al_data;
    logic [4:0] ev, clr;

    // unmapped offsets answer with an error
    function automatic logic addr_hit(input logic [11:0] a);
        return a == tosc_pkg::OFF_CTRL || a == tosc_pkg::OFF_STAT ||
               a == tosc_pkg::OFF_IRQ_STAT || a == tosc_pkg::OFF_IRQ_EN ||
               a == tosc_pkg::OFF_IRQ_CLR || a == tosc_pkg::OFF_STREAM_ID ||
               a == tosc_pkg::OFF_FEAT5;
    endfunction

    // read mux; unmapped reads return zero
    function automatic logic [31:0] rd_word(input logic [11:0] a, input tosc_top_st_t s);
        logic [31:0] w;
        w = 32'h0;
        unique case (a)
            tosc_pkg::OFF_CTRL: w[4:0] = s.ctrl;
            tosc_pkg::OFF_STAT: begin
                w[tosc_pkg::STAT_ENABLED] = s.sess != tosc_pkg::TOSC_DISABLED;
                w[tosc_pkg::STAT_OPER] = s.sess == tosc_pkg::TOSC_OPERATIVE;
                w[tosc_pkg::STAT_RECOV] = s.sess == tosc_pkg::TOSC_RECOVERING;
                w[tosc_pkg::STAT_VIEW] = s.view;
                w[tosc_pkg::STAT_BUSY] = s.out_vld != 3'h0;
            end
            tosc_pkg::OFF_IRQ_STAT: w[4:0] = s.ev_stat;
            tosc_pkg::OFF_IRQ_EN: w[4:0] = s.ev_en;
            tosc_pkg::OFF_STREAM_ID: w[6:0] = s.sid;
            tosc_pkg::OFF_FEAT5: w = tosc_pkg::FEAT5_VALUE;
            default: w = 32'h0;
        endcase
        return w;
    endfunction

    tosc_route u_route (
        .tbu_en(st_reg.ctrl[tosc_pkg::CTRL_TBU_EN]),
        .atb_en(st_reg.ctrl[tosc_pkg::CTRL_ATB_EN]),
        .imp_en(st_reg.ctrl[tosc_pkg::CTRL_IMP_EN]),
        .dest(dest)
    );

    // sync restarts each time generation turns operative
    tosc_align u_align (
        .pclk(pclk),
        .presetn(presetn),
        .start(start),
        .clear(!oper),
        .take(sy_v & take),
        .busy(al_busy),
        .data(al_data)
    );

    // access phase takes one wait state; the write lands on the pready edge
    assign access = psel & penable & !st_reg.pready;
    assign wr = psel & penable & pwrite & st_reg.pready;
    assign clr = (wr && paddr == tosc_pkg::OFF_IRQ_CLR) ? pwdata[4:0] : 5'h0;

    assign oper = st_reg.sess == tosc_pkg::TOSC_OPERATIVE;
    assign unit_en = st_reg.ctrl[tosc_pkg::CTRL_UNIT_EN];
    // each sink clears only its own valid
    assign done_vld = st_reg.out_vld & {imp_ready, atb_ready, tbu_ready};
    assign vld_after = st_reg.out_vld & ~done_vld;
    assign slot_free = vld_after == 3'h0;

    assign sy_v = oper & al_busy;
    assign sp_v = oper & st_reg.view & retire_valid & retire_signpost;
    assign pk_v = oper & pkt_valid;
    assign want = sy_v | sp_v | pk_v;
    assign multi = (sy_v & (sp_v | pk_v)) | (sp_v & pk_v);
    // a single output slot: a second byte or a busy slot means a lost packet;
    // the sync sequencer only waits on a busy slot, since it holds its own byte
    assign lost = (sp_v | pk_v) & (dest != 3'h0) & (multi | !slot_free);
    assign take = want & !lost & (slot_free | (dest == 3'h0));
    assign byte_sel = sy_v ? al_data : (sp_v ? tosc_pkg::SIGNPOST_BYTE : pkt_data);
    // resync only from a quiet cycle with a free slot; a packet in the first operative cycle still collides with the sync
    assign recover_ok = slot_free & !pkt_valid & !(retire_valid & retire_signpost);

    always_comb begin
        st_next = st_reg;
        ev = tosc_pkg::EV_RST;
        start = 1'b0;
        st_next.pready = access;
        st_next.pslverr = access & !addr_hit(paddr);
        if (access & !pwrite) begin
            st_next.prdata = rd_word(paddr, st_reg);
        end
        if (wr && paddr == tosc_pkg::OFF_CTRL) begin
            st_next.ctrl = pwdata[4:0];
        end
        if (wr && paddr == tosc_pkg::OFF_STREAM_ID) begin
            st_next.sid = pwdata[6:0];
        end
        if (wr && paddr == tosc_pkg::OFF_IRQ_EN) begin
            st_next.ev_en = pwdata[4:0];
        end
        // a byte only ever lands in an empty slot
        st_next.out_vld = vld_after;
        if (take && dest != 3'h0) begin
            st_next.out_vld = dest;
            st_next.out_data = byte_sel;
        end
        unique case (st_reg.sess)
            tosc_pkg::TOSC_DISABLED: begin
                if (unit_en) begin
                    st_next.sess = tosc_pkg::TOSC_OPERATIVE;
                    start = 1'b1;
                    ev[tosc_pkg::EV_START] = 1'b1;
                end
            end
            tosc_pkg::TOSC_OPERATIVE: begin
                if (!unit_en) begin
                    st_next.sess = tosc_pkg::TOSC_DISABLED;
                    ev[tosc_pkg::EV_END] = 1'b1;
                end else if (lost) begin
                    st_next.sess = tosc_pkg::TOSC_RECOVERING;
                    ev[tosc_pkg::EV_OVF] = 1'b1;
                end
            end
            tosc_pkg::TOSC_RECOVERING: begin
                if (!unit_en) begin
                    st_next.sess = tosc_pkg::TOSC_DISABLED;
                    ev[tosc_pkg::EV_END] = 1'b1;
                end else if (recover_ok) begin
                    st_next.sess = tosc_pkg::TOSC_OPERATIVE;
                    start = 1'b1;
                    ev[tosc_pkg::EV_RECOVER] = 1'b1;
                end
            end
            default: st_next.sess = tosc_pkg::TOSC_DISABLED;
        endcase
        if (atb_trig_in & st_reg.ctrl[tosc_pkg::CTRL_ATB_EN]) begin
            ev[tosc_pkg::EV_TRIG] = 1'b1;
        end
        // warm reset ends the session but leaves pending sink bytes and the id alone
        if (!warm_rstn) begin
            st_next.ctrl = tosc_pkg::CTRL_RST;
            st_next.sess = tosc_pkg::TOSC_DISABLED;
            start = 1'b0;
        end
        // set beats clear in the same cycle
        st_next.ev_stat = (st_reg.ev_stat & ~clr) | ev;
        st_next.irq = |(st_next.ev_stat & st_next.ev_en);
        st_next.oper = st_next.sess == tosc_pkg::TOSC_OPERATIVE;
        st_next.view = st_next.ctrl[tosc_pkg::CTRL_VIEW] &
                       (st_next.sess != tosc_pkg::TOSC_DISABLED);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_reg <= '{ctrl: tosc_pkg::CTRL_RST, sid: tosc_pkg::SID_RST,
                        ev_stat: tosc_pkg::EV_RST, ev_en: tosc_pkg::EV_RST,
                        sess: tosc_pkg::TOSC_DISABLED, out_vld: 3'h0, out_data: 8'h00,
                        pready: 1'b0, pslverr: 1'b0, prdata: 32'h0, irq: 1'b0,
                        view: 1'b0, oper: 1'b0};
        end else begin
            st_reg <= st_next;
        end
    end

    // every output is a register field
    assign pready = st_reg.pready;
    assign prdata = st_reg.prdata;
    assign pslverr = st_reg.pslverr;
    assign tbu_valid = st_reg.out_vld[tosc_pkg::DST_TBU];
    assign atb_valid = st_reg.out_vld[tosc_pkg::DST_ATB];
    assign imp_valid = st_reg.out_vld[tosc_pkg::DST_IMP];
    assign tbu_data = st_reg.out_data;
    assign atb_data = st_reg.out_data;
    assign imp_data = st_reg.out_data;
    assign atb_id = st_reg.sid;
    assign view_active = st_reg.view;
    assign gen_operative = st_reg.oper;
    assign irq = st_reg.irq;

    // checks below watch session and slot state on pclk
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // a session start and its first sync
    sequence s_turn_on;
        st_reg.sess != tosc_pkg::TOSC_OPERATIVE ##1 st_reg.sess == tosc_pkg::TOSC_OPERATIVE;
    endsequence
    sequence s_enable_cmd;
        st_reg.sess == tosc_pkg::TOSC_DISABLED && unit_en && warm_rstn;
    endsequence

    property p_sync_first;
        s_turn_on |-> al_busy && !sp_v || al_busy;
    endproperty
    a_sync_first: assert property (p_sync_first) else $error("no sync on turn on");
    property p_tbu_only;
        take && st_reg.ctrl[tosc_pkg::CTRL_TBU_EN] |=> st_reg.out_vld == 3'h1;
    endproperty
    a_tbu_only: assert property (p_tbu_only) else $error("byte left buffer path");
    property p_other_out;
        take && !st_reg.ctrl[tosc_pkg::CTRL_TBU_EN] && st_reg.ctrl[tosc_pkg::CTRL_ATB_EN]
            |=> atb_valid && !tbu_valid;
    endproperty
    a_other_out: assert property (p_other_out) else $error("atb path not used");
    property p_discard;
        oper && dest == 3'h0 |=> st_reg.sess != tosc_pkg::TOSC_RECOVERING;
    endproperty
    a_discard: assert property (p_discard) else $error("overflow with outputs off");
    property p_legal_state;
        st_reg.sess == tosc_pkg::TOSC_DISABLED || st_reg.sess == tosc_pkg::TOSC_OPERATIVE ||
        st_reg.sess == tosc_pkg::TOSC_RECOVERING;
    endproperty
    a_legal_state: assert property (p_legal_state) else $error("illegal session state");
    property p_session_start;
        s_enable_cmd |=> st_reg.ev_stat[tosc_pkg::EV_START] && gen_operative ##1 sy_v;
    endproperty
    a_session_start: assert property (p_session_start) else $error("session did not start");
    property p_overflow;
        oper && lost && unit_en && warm_rstn
            |=> st_reg.sess == tosc_pkg::TOSC_RECOVERING && !gen_operative;
    endproperty
    a_overflow: assert property (p_overflow) else $error("overflow not entered");
    property p_recover_hold;
        st_reg.sess == tosc_pkg::TOSC_RECOVERING && !slot_free |=> !gen_operative;
    endproperty
    a_recover_hold: assert property (p_recover_hold) else $error("early recovery");
    property p_view_indep;
        st_reg.sess == tosc_pkg::TOSC_RECOVERING && st_reg.ctrl[tosc_pkg::CTRL_VIEW] &&
        unit_en && warm_rstn && !wr |=> view_active && gen_operative == $past(recover_ok);
    endproperty
    a_view_indep: assert property (p_view_indep) else $error("view tied to operative");

    // recovery and first enable both restart the sync sequencer at once
    sequence s_resync;
        gen_operative && al_busy;
    endsequence

    property p_recover_sync;
        st_reg.sess == tosc_pkg::TOSC_RECOVERING && recover_ok && unit_en && warm_rstn
            |=> s_resync;
    endproperty
    a_recover_sync: assert property (p_recover_sync) else $error("no resync after recovery");

    property p_overflow_flag;
        oper && unit_en && (sp_v || pk_v) && !slot_free && dest != 3'h0
            |=> st_reg.ev_stat[tosc_pkg::EV_OVF];
    endproperty
    a_overflow_flag: assert property (p_overflow_flag) else $error("lost byte not flagged");

    property p_byte_out;
        take && dest != 3'h0
            |=> st_reg.out_data == $past(byte_sel) && st_reg.out_vld == $past(dest);
    endproperty
    a_byte_out: assert property (p_byte_out) else $error("taken byte not on outputs");

    property p_plain_retire;
        oper && retire_valid && !retire_signpost && !pkt_valid && !al_busy && slot_free
            |=> st_reg.out_vld == 3'h0;
    endproperty
    a_plain_retire: assert property (p_plain_retire) else $error("byte for plain retire");

    property p_off_quiet;
        dest == 3'h0 && slot_free |=> st_reg.out_vld == 3'h0;
    endproperty
    a_off_quiet: assert property (p_off_quiet) else $error("byte sent with outputs off");

    property p_warm_keep;
        !warm_rstn && !wr |=> (st_reg.out_vld & $past(vld_after)) == $past(vld_after) &&
            atb_id == $past(atb_id) && st_reg.ctrl == tosc_pkg::CTRL_RST;
    endproperty
    a_warm_keep: assert property (p_warm_keep) else $error("warm reset hit output path");
endmodule
`default_nettype wire

// file: common/tosc_pkg.sv
// package for the trace output and session control block
// assumes: one APB bus, one clock, trace sinks answering with valid/ready
package tosc_pkg;
    localparam int ADDR_W = 12;
    localparam logic [11:0] OFF_CTRL = 12'h000;
    localparam logic [11:0] OFF_STAT = 12'h004;
    localparam logic [11:0] OFF_IRQ_STAT = 12'h008;
    localparam logic [11:0] OFF_IRQ_EN = 12'h00c;
    localparam logic [11:0] OFF_IRQ_CLR = 12'h010;
    localparam logic [11:0] OFF_STREAM_ID = 12'h014;
    localparam logic [11:0] OFF_FEAT5 = 12'h018;

    localparam int CTRL_W = 5;
    localparam int CTRL_UNIT_EN = 0;
    localparam int CTRL_TBU_EN = 1;
    localparam int CTRL_ATB_EN = 2;
    localparam int CTRL_IMP_EN = 3;
    localparam int CTRL_VIEW = 4;
    localparam logic [4:0] CTRL_RST = 5'h00;

    localparam int SRC_ID_W = 7;
    localparam logic [6:0] SID_RST = 7'h00;

    localparam int STAT_ENABLED = 0;
    localparam int STAT_OPER = 1;
    localparam int STAT_RECOV = 2;
    localparam int STAT_VIEW = 3;
    localparam int STAT_BUSY = 4;

    localparam int EV_W = 5;
    localparam int EV_OVF = 0;
    localparam int EV_RECOVER = 1;
    localparam int EV_START = 2;
    localparam int EV_END = 3;
    localparam int EV_TRIG = 4;
    localparam logic [4:0] EV_RST = 5'h00;

    localparam int DST_W = 3;
    localparam int DST_TBU = 0;
    localparam int DST_ATB = 1;
    localparam int DST_IMP = 2;

    // bit 0: trigger support, bits 4:1: source identifier width (7)
    localparam logic [31:0] FEAT5_VALUE = 32'h0000000f;

    localparam logic [3:0] ALIGN_LEN = 4'h6;
    localparam logic [7:0] ALIGN_FILL = 8'h00;
    localparam logic [7:0] ALIGN_LAST = 8'h80;
    localparam logic [7:0] SIGNPOST_BYTE = 8'hfe;

    typedef enum logic [1:0] {
        TOSC_DISABLED = 2'b00,
        TOSC_OPERATIVE = 2'b01,
        TOSC_RECOVERING = 2'b10
    } tosc_sess_t;

    typedef enum logic {
        TOSC_AL_IDLE = 1'b0,
        TOSC_AL_EMIT = 1'b1
    } tosc_align_t;
endpackage

// file: design/tosc_route.sv
// sink selection for the trace byte stream
// assumes: enables come from the control register of the same clock
`timescale 1ns/1ps
`default_nettype none
module tosc_route (
    input wire logic tbu_en,
    input wire logic atb_en,
    input wire logic imp_en,
    output logic [2:0] dest
);
    always_comb begin
        dest = 3'h0;
        if (tbu_en) begin
            dest[tosc_pkg::DST_TBU] = 1'b1;
        end else begin
            dest[tosc_pkg::DST_ATB] = atb_en;
            dest[tosc_pkg::DST_IMP] = imp_en;
        end
    end
endmodule
`default_nettype wire

// file: design/tosc_align.sv
// alignment synchronization byte sequencer
// assumes: start wins over clear; take only while busy
`timescale 1ns/1ps
`default_nettype none
module tosc_align (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic start,
    input wire logic clear,
    input wire logic take,
    output logic busy,
    output logic [7:0] data
);
    typedef struct packed {
        tosc_pkg::tosc_align_t state;
        logic [3:0] cnt;
    } tosc_al_st_t;

    tosc_al_st_t st_reg;
    tosc_al_st_t st_next;

    always_comb begin
        st_next = st_reg;
        unique case (st_reg.state)
            tosc_pkg::TOSC_AL_IDLE: begin
                st_next.cnt = 4'h0;
            end
            tosc_pkg::TOSC_AL_EMIT: begin
                if (take) begin
                    if (st_reg.cnt == tosc_pkg::ALIGN_LEN - 4'h1) begin
                        st_next.state = tosc_pkg::TOSC_AL_IDLE;
                    end
                    st_next.cnt = 4'(st_reg.cnt + 4'h1);
                end
            end
        endcase
        if (clear) begin
            st_next.state = tosc_pkg::TOSC_AL_IDLE;
        end
        if (start) begin
            st_next.state = tosc_pkg::TOSC_AL_EMIT;
            st_next.cnt = 4'h0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_reg <= '{state: tosc_pkg::TOSC_AL_IDLE, cnt: 4'h0};
        end else begin
            st_reg <= st_next;
        end
    end

    assign busy = st_reg.state == tosc_pkg::TOSC_AL_EMIT;
    assign data = (st_reg.cnt == tosc_pkg::ALIGN_LEN - 4'h1) ? tosc_pkg::ALIGN_LAST
                                                              : tosc_pkg::ALIGN_FILL;
endmodule
`default_nettype wire

// file: testbench/tosc_sink_model.sv
// behavioural trace capture sink standing on one byte output of the block
// assumes: the bench reads the got queue by hierarchy and picks the mode
`timescale 1ns/1ps
`default_nettype none
module tosc_sink_model (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic valid,
    input wire logic [7:0] data,
    input wire logic [1:0] mode,
    output logic ready
);
    logic [7:0] got[$];

    // mode 0 always ready, 1 random stalls, 2 refuses everything
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ready <= 1'b0;
        end else begin
            if (valid && ready) got.push_back(data);
            ready <= (mode == 2'h0) || (mode == 2'h1 && $urandom_range(1) == 1);
        end
    end
endmodule
`default_nettype wire

// file: testbench/test_trace_output_session_control.sv
// self-checking bench for the trace output and session control block
// assumes: three sink models on the byte outputs, APB master tasks in here
`timescale 1ns/1ps
`default_nettype none
module test_trace_output_session_control;
    logic pclk, presetn, warm_rstn, psel, penable, pwrite, pready, pslverr;
    logic pkt_valid, retire_valid, retire_signpost, atb_trig_in, irq, er;
    logic tbu_valid, tbu_ready, atb_valid, atb_ready, imp_valid, imp_ready;
    logic view_active, gen_operative;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [7:0] pkt_data, tbu_data, atb_data, imp_data, b;
    logic [6:0] atb_id, sid;
    logic [1:0] m_tbu, m_atb, m_imp;
    logic [4:0] cur;
    logic [4:0] routes [6] = '{5'h05, 5'h09, 5'h0d, 5'h07, 5'h0f, 5'h01};
    logic [7:0] e_tbu[$], e_atb[$], e_imp[$];
    int mismatches, n_compared;

    tosc_top DUT (.pclk(pclk), .presetn(presetn), .warm_rstn(warm_rstn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
        .prdata(prdata), .pslverr(pslverr), .pkt_valid(pkt_valid), .pkt_data(pkt_data),
        .retire_valid(retire_valid), .retire_signpost(retire_signpost),
        .tbu_valid(tbu_valid), .tbu_data(tbu_data), .tbu_ready(tbu_ready),
        .atb_valid(atb_valid), .atb_data(atb_data), .atb_id(atb_id), .atb_ready(atb_ready),
        .atb_trig_in(atb_trig_in), .imp_valid(imp_valid), .imp_data(imp_data),
        .imp_ready(imp_ready), .view_active(view_active), .gen_operative(gen_operative),
        .irq(irq));
    tosc_sink_model u_tbu (.pclk(pclk), .presetn(presetn), .valid(tbu_valid),
        .data(tbu_data), .mode(m_tbu), .ready(tbu_ready));
    tosc_sink_model u_atb (.pclk(pclk), .presetn(presetn), .valid(atb_valid),
        .data(atb_data), .mode(m_atb), .ready(atb_ready));
    tosc_sink_model u_imp (.pclk(pclk), .presetn(presetn), .valid(imp_valid),
        .data(imp_data), .mode(m_imp), .ready(imp_ready));

    always #12.5 pclk = ~pclk;

    task automatic end_sim();
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic timeout();
        mismatches++;
        $display("wait limit used up at %0t", $time);
        end_sim();
    endtask

    task automatic chk32(logic [31:0] got, logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic cmp_q(ref logic [7:0] g[$], ref logic [7:0] e[$]);
        chk32(32'(g.size()), 32'(e.size()));
        foreach (e[j]) if (j < g.size()) chk32(32'(g[j]), 32'(e[j]));
        g.delete();
        e.delete();
    endtask

    // entered just after a rising edge; leaves one idle cycle behind it
    task automatic apb(logic w, logic [11:0] a, logic [31:0] d, output logic [31:0] x,
                       output logic e);
        int i;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        for (i = 0; i < 20; i++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        if (i == 20) timeout();
        x = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic wr(logic [11:0] a, logic [31:0] d);
        logic [31:0] x;
        logic e;
        apb(1'b1, a, d, x, e);
    endtask

    task automatic rdchk(logic [11:0] a, logic [31:0] exp);
        logic [31:0] x;
        logic e;
        apb(1'b0, a, 32'h0, x, e);
        chk32(x, exp);
    endtask

    task automatic set_ctrl(logic [4:0] c);
        cur = c;
        wr(tosc_pkg::OFF_CTRL, 32'(c));
    endtask

    // the buffer unit takes the whole stream, otherwise every enabled output
    task automatic exp_b(logic [7:0] v);
        if (cur[tosc_pkg::CTRL_TBU_EN]) begin
            e_tbu.push_back(v);
        end else begin
            if (cur[tosc_pkg::CTRL_ATB_EN]) e_atb.push_back(v);
            if (cur[tosc_pkg::CTRL_IMP_EN]) e_imp.push_back(v);
        end
    endtask

    task automatic add_sync();
        for (int i = 1; i < tosc_pkg::ALIGN_LEN; i++) exp_b(tosc_pkg::ALIGN_FILL);
        exp_b(tosc_pkg::ALIGN_LAST);
    endtask

    task automatic chk_q();
        int i;
        for (i = 0; i < 300; i++) begin
            if (u_tbu.got.size() >= e_tbu.size() && u_atb.got.size() >= e_atb.size()
                && u_imp.got.size() >= e_imp.size()) break;
            @(posedge pclk);
        end
        if (i == 300) timeout();
        cmp_q(u_tbu.got, e_tbu);
        cmp_q(u_atb.got, e_atb);
        cmp_q(u_imp.got, e_imp);
    endtask

    task automatic wait_op(logic v);
        int i;
        for (i = 0; i < 50 && gen_operative !== v; i++) @(posedge pclk);
        if (i == 50) timeout();
        chk32(32'(gen_operative), 32'(v));
    endtask

    // k: 0 packet byte, 1 signpost retire, 2 plain retire; lim 0 means one cycle and no time limit
    task automatic emit(int k, logic [7:0] v, int lim);
        int i;
        pkt_valid <= (k == 0);
        pkt_data <= v;
        retire_valid <= (k != 0);
        retire_signpost <= (k == 1);
        @(posedge pclk);
        pkt_valid <= 1'b0;
        retire_valid <= 1'b0;
        for (i = 0; i <= lim; i++) begin
            @(posedge pclk);
            if (!(tbu_valid || atb_valid || imp_valid)) break;
        end
        if (lim > 0 && i > lim) timeout();
    endtask

    initial begin
        pclk = 1'b0;
        presetn = 1'b0;
        warm_rstn = 1'b1;
        {psel, penable, pwrite, pkt_valid, retire_valid, retire_signpost, atb_trig_in} = '0;
        {paddr, pwdata, pkt_data, m_tbu, m_atb, m_imp, cur} = '0;
        mismatches = 0;
        n_compared = 0;
        void'($urandom(16));
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rdchk(tosc_pkg::OFF_CTRL, 32'h0);
        rdchk(tosc_pkg::OFF_STAT, 32'h0);
        rdchk(tosc_pkg::OFF_IRQ_STAT, 32'h0);
        rdchk(tosc_pkg::OFF_FEAT5, tosc_pkg::FEAT5_VALUE);
        wr(tosc_pkg::OFF_FEAT5, 32'hffffffff);
        rdchk(tosc_pkg::OFF_FEAT5, tosc_pkg::FEAT5_VALUE);
        apb(1'b0, 12'h01c, 32'h0, rd, er);
        chk32(32'(er), 32'h1);
        chk32(rd, 32'h0);
        sid = 7'($urandom());
        wr(tosc_pkg::OFF_STREAM_ID, 32'(sid));
        rdchk(tosc_pkg::OFF_STREAM_ID, 32'(sid));
        chk32(32'(atb_id), 32'(sid));
        $display("test registers done");
        foreach (routes[k]) begin
            m_atb <= 2'($urandom_range(1));
            m_imp <= 2'($urandom_range(1));
            set_ctrl(routes[k]);
            add_sync();
            wait_op(1'b1);
            chk_q();
            rdchk(tosc_pkg::OFF_STAT, 32'h03);
            repeat (3) begin
                b = 8'($urandom());
                exp_b(b);
                emit(0, b, 50);
            end
            chk_q();
            set_ctrl(5'h00);
            wait_op(1'b0);
            rdchk(tosc_pkg::OFF_IRQ_STAT, 32'h0c);
            wr(tosc_pkg::OFF_IRQ_CLR, 32'h1f);
        end
        $display("test routing done");
        set_ctrl(5'h13);
        add_sync();
        wait_op(1'b1);
        chk_q();
        chk32(32'(view_active), 32'h1);
        exp_b(tosc_pkg::SIGNPOST_BYTE);
        emit(1, 8'h00, 50);
        emit(2, 8'h00, 50);
        chk_q();
        set_ctrl(5'h03);
        emit(1, 8'h00, 50);
        chk_q();
        chk32({30'h0, view_active, gen_operative}, 32'h1);
        $display("test signpost done");
        set_ctrl(5'h13);
        wr(tosc_pkg::OFF_IRQ_CLR, 32'h1f);
        wr(tosc_pkg::OFF_IRQ_EN, 32'h01);
        m_tbu <= 2'h2;
        b = 8'($urandom());
        exp_b(b);
        emit(0, b, 0);
        emit(0, 8'($urandom()), 0);
        rdchk(tosc_pkg::OFF_STAT, 32'h1d);
        chk32({29'h0, irq, view_active, gen_operative}, 32'h6);
        m_tbu <= 2'h0;
        add_sync();
        wait_op(1'b1);
        chk_q();
        rdchk(tosc_pkg::OFF_IRQ_STAT, 32'h03);
        wr(tosc_pkg::OFF_IRQ_CLR, 32'h01);
        rdchk(tosc_pkg::OFF_IRQ_STAT, 32'h02);
        chk32(32'(irq), 32'h0);
        wr(tosc_pkg::OFF_IRQ_EN, 32'h02);
        rdchk(tosc_pkg::OFF_IRQ_EN, 32'h02);
        chk32(32'(irq), 32'h1);
        $display("test overflow done");
        set_ctrl(5'h00);
        wait_op(1'b0);
        wr(tosc_pkg::OFF_IRQ_CLR, 32'h1f);
        set_ctrl(5'h05);
        add_sync();
        wait_op(1'b1);
        chk_q();
        atb_trig_in <= 1'b1;
        @(posedge pclk);
        atb_trig_in <= 1'b0;
        rdchk(tosc_pkg::OFF_IRQ_STAT, 32'h14);
        $display("test trigger done");
        warm_rstn <= 1'b0;
        @(posedge pclk);
        warm_rstn <= 1'b1;
        wait_op(1'b0);
        rdchk(tosc_pkg::OFF_CTRL, 32'h0);
        rdchk(tosc_pkg::OFF_IRQ_STAT, 32'h14);
        chk32(32'(atb_id), 32'(sid));
        $display("test warm reset done");
        end_sim();
    end
endmodule
`default_nettype wire
